// [rtl/dacrs_defines.svh]
// Constants of the converter register set: bus address, command codes,
// field positions, reset values and counts.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef DACRS_DEFINES_SVH
`define DACRS_DEFINES_SVH

`define DACRS_SLAVE_ADDR 7'h48
`define DACRS_CMD_CODE 8'h00
`define DACRS_CMD_SETTINGS 8'h01
`define DACRS_CODE_RESET 8'h00
`define DACRS_SETTINGS_RESET 8'h00
`define DACRS_STANDBY_BIT 0
`define DACRS_BITS_PER_BYTE 4'h8
`define DACRS_RW_READ 1'b1

`endif

// [rtl/dacrs_pkg.sv]
// Types shared by the converter register set.
// Assumes dacrs_defines.svh on the include path.
`default_nettype none

package dacrs_pkg;

	// Gray codes along the write path; AACK to RDAT changes three bits
	typedef enum logic [3:0] {
		DACRS_IDLE = 4'h0,
		DACRS_ADDR = 4'h1,
		DACRS_AACK = 4'h3,
		DACRS_CMD = 4'h2,
		DACRS_CACK = 4'h6,
		DACRS_WDAT = 4'h7,
		DACRS_WACK = 4'h5,
		DACRS_RDAT = 4'h4,
		DACRS_MACK = 4'hc,
		DACRS_SKIP = 4'hd
	} dacrs_state_e;

	// Bus conditions seen on the synchronised pins
	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
	} dacrs_bus_ev_s;

endpackage

`default_nettype wire

// [rtl/dacrs_top.sv]
// Two-wire slave with the converter's code and settings registers.
// Assumes an external host driving the serial clock and an open-drain
// data wire resolved outside; clk_in is much faster than the bus clock.
`include "dacrs_defines.svh"
`default_nettype none

// What this block does
// - Command 00h selects the code register
// - Command 01h selects the settings register
// - Settings bit 0 is standby select
// - Settings bits 7..1 always read zero
// - Power-on reset clears both registers
// - Both registers eight bits; code read and write, settings only bit 0
// - Stored code drives the converter
// - Read-byte, write-byte and receive-byte access registers
// - Answer only address 1001000, bit eight direction
// - Standby halts conversion, bus keeps working
// - Receive-byte returns last selected register
module dacrs_top (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Serial pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Converter side
	output logic [7:0] dac_code_out,
	output logic standby_out,
	output logic conv_en_out
);

	logic [2:0] scl_sync_ff;
	logic [2:0] sda_sync_ff;
	dacrs_pkg::dacrs_state_e state_ff, nxt_state;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] shift_ff, nxt_shift;
	logic [7:0] ptr_ff, nxt_ptr;
	logic rw_ff, nxt_rw;
	logic mack_ff, nxt_mack;
	logic oe_ff, nxt_oe;
	logic [7:0] code_ff, nxt_code;
	logic stby_ff, nxt_stby;
	logic conv_en_ff;
	// Only the standby bit of the settings reset value is stored
	localparam logic [7:0] set_rst_val = `DACRS_SETTINGS_RESET;

	// Bits 0 feed bit 1 only; edges compare the second and third stages
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			scl_sync_ff <= 3'h7;
			sda_sync_ff <= 3'h7;
		end
		else
		begin
			scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
			sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
		end
	end

	wire scl_s = scl_sync_ff[1];
	wire scl_d = scl_sync_ff[2];
	wire sda_s = sda_sync_ff[1];
	wire sda_d = sda_sync_ff[2];
	dacrs_pkg::dacrs_bus_ev_s ev;
	assign ev.start = scl_s & scl_d & sda_d & ~sda_s;
	assign ev.stop = scl_s & scl_d & ~sda_d & sda_s;
	assign ev.rise = scl_s & ~scl_d;
	assign ev.fall = ~scl_s & scl_d;

	wire byte_done = (cnt_ff == `DACRS_BITS_PER_BYTE);
	wire addr_hit = (shift_ff[7:1] == `DACRS_SLAVE_ADDR);
	wire sel_code = (ptr_ff == `DACRS_CMD_CODE);
	wire sel_set = (ptr_ff == `DACRS_CMD_SETTINGS);
	wire [7:0] set_val = {7'h00, stby_ff};
	// Pointer survives transactions so receive-byte reuses it
	wire [7:0] rd_val = sel_code ? code_ff :
		(sel_set ? set_val : 8'h00);
	wire rx_state = (state_ff == dacrs_pkg::DACRS_ADDR) ||
		(state_ff == dacrs_pkg::DACRS_CMD) ||
		(state_ff == dacrs_pkg::DACRS_WDAT);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_shift = shift_ff;
		nxt_ptr = ptr_ff;
		nxt_rw = rw_ff;
		nxt_mack = mack_ff;
		nxt_oe = oe_ff;
		nxt_code = code_ff;
		nxt_stby = stby_ff;
		if (ev.stop)
		begin
			nxt_state = dacrs_pkg::DACRS_IDLE;
			nxt_oe = 1'b0;
		end
		else if (ev.start)
		begin
			// Also a repeated start from any state
			nxt_state = dacrs_pkg::DACRS_ADDR;
			nxt_cnt = 4'h0;
			nxt_oe = 1'b0;
		end
		else if (ev.rise)
		begin
			if (rx_state)
			begin
				nxt_shift = {shift_ff[6:0], sda_s};
				nxt_cnt = cnt_ff + 4'h1;
			end
			else if (state_ff == dacrs_pkg::DACRS_RDAT)
				nxt_cnt = cnt_ff + 4'h1;
			else if (state_ff == dacrs_pkg::DACRS_MACK)
				nxt_mack = ~sda_s;
		end
		else if (ev.fall)
		begin
			unique case (state_ff)
				dacrs_pkg::DACRS_ADDR:
					if (byte_done)
					begin
						if (addr_hit)
						begin
							nxt_state = dacrs_pkg::DACRS_AACK;
							nxt_oe = 1'b1;
							nxt_rw = shift_ff[0];
						end
						else
							nxt_state = dacrs_pkg::DACRS_SKIP;
					end
				dacrs_pkg::DACRS_AACK:
				begin
					nxt_cnt = 4'h0;
					if (rw_ff == `DACRS_RW_READ)
					begin
						nxt_state = dacrs_pkg::DACRS_RDAT;
						nxt_shift = rd_val;
						nxt_oe = ~rd_val[7];
					end
					else
					begin
						nxt_state = dacrs_pkg::DACRS_CMD;
						nxt_oe = 1'b0;
					end
				end
				dacrs_pkg::DACRS_CMD:
					if (byte_done)
					begin
						nxt_state = dacrs_pkg::DACRS_CACK;
						nxt_oe = 1'b1;
						nxt_ptr = shift_ff;
					end
				dacrs_pkg::DACRS_CACK,
				dacrs_pkg::DACRS_WACK:
				begin
					nxt_state = dacrs_pkg::DACRS_WDAT;
					nxt_oe = 1'b0;
					nxt_cnt = 4'h0;
				end
				dacrs_pkg::DACRS_WDAT:
					if (byte_done)
					begin
						nxt_state = dacrs_pkg::DACRS_WACK;
						nxt_oe = 1'b1;
						if (sel_code)
							nxt_code = shift_ff;
						if (sel_set)
							nxt_stby = shift_ff[`DACRS_STANDBY_BIT];
					end
				dacrs_pkg::DACRS_RDAT:
					if (byte_done)
					begin
						nxt_state = dacrs_pkg::DACRS_MACK;
						nxt_oe = 1'b0;
					end
					else
					begin
						// Bits leave MSB first; drive low for a zero
						nxt_shift = {shift_ff[6:0], 1'b0};
						nxt_oe = ~shift_ff[6];
					end
				dacrs_pkg::DACRS_MACK:
					if (mack_ff)
					begin
						nxt_state = dacrs_pkg::DACRS_RDAT;
						nxt_cnt = 4'h0;
						nxt_shift = rd_val;
						nxt_oe = ~rd_val[7];
					end
					else
						nxt_state = dacrs_pkg::DACRS_SKIP;
				default:
					nxt_oe = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_ff <= dacrs_pkg::DACRS_IDLE;
			cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			ptr_ff <= `DACRS_CMD_CODE;
			rw_ff <= 1'b0;
			mack_ff <= 1'b0;
			oe_ff <= 1'b0;
			code_ff <= `DACRS_CODE_RESET;
			stby_ff <= set_rst_val[`DACRS_STANDBY_BIT];
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			shift_ff <= nxt_shift;
			ptr_ff <= nxt_ptr;
			rw_ff <= nxt_rw;
			mack_ff <= nxt_mack;
			oe_ff <= nxt_oe;
			code_ff <= nxt_code;
			stby_ff <= nxt_stby;
		end
	end

	// Serial port keeps running in standby; only the converter stops
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			conv_en_ff <= 1'b0;
		else
			conv_en_ff <= ~stby_ff;
	end

	assign sda_out = 1'b0;
	assign sda_oe_out = oe_ff;
	assign dac_code_out = code_ff;
	assign standby_out = stby_ff;
	assign conv_en_out = conv_en_ff;

	reserved_zero_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		sel_set |-> rd_val[7:1] == 7'h00)
		else $error("settings reserved bits not zero");
	reset_clear_a: assert property (
		@(posedge clk_in)
		$rose(rst_n_in) |-> code_ff == 8'h00 && !stby_ff)
		else $error("registers not clear after reset");
	code_write_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		state_ff == dacrs_pkg::DACRS_WDAT && ev.fall && byte_done &&
		sel_code |=> code_ff == $past(shift_ff) &&
		state_ff == dacrs_pkg::DACRS_WACK && sda_oe_out)
		else $error("code write lost");
	stby_write_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		state_ff == dacrs_pkg::DACRS_WDAT && ev.fall && byte_done &&
		sel_set |=> stby_ff == $past(shift_ff[0]))
		else $error("standby write lost");
	bad_cmd_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		state_ff == dacrs_pkg::DACRS_WDAT && ev.fall && !sel_code &&
		!sel_set |=> $stable(code_ff) && $stable(stby_ff))
		else $error("unknown command changed a register");
	read_load_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		state_ff == dacrs_pkg::DACRS_AACK && ev.fall && !ev.start &&
		!ev.stop && rw_ff |=> shift_ff == $past(rd_val) &&
		sda_oe_out == ~shift_ff[7])
		else $error("read byte not loaded from pointer");
	addr_miss_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		state_ff == dacrs_pkg::DACRS_ADDR && ev.fall && byte_done &&
		!addr_hit |=> state_ff == dacrs_pkg::DACRS_SKIP ##1 !sda_oe_out)
		else $error("foreign address answered");
	halt_conv_a: assert property (
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(stby_ff) |=> !conv_en_out [*2])
		else $error("conversion not halted in standby");
	cover_code_write: cover property (@(posedge clk_in)
		state_ff == dacrs_pkg::DACRS_WACK && sel_code);
	cover_read: cover property (@(posedge clk_in)
		state_ff == dacrs_pkg::DACRS_MACK);
	cover_standby: cover property (@(posedge clk_in) $rose(stby_ff));
	cover_burst: cover property (@(posedge clk_in)
		state_ff == dacrs_pkg::DACRS_MACK && mack_ff && ev.fall);

endmodule

`default_nettype wire

// [verif/dacrs_host.sv]
// Host model: two-wire master with bit and byte tasks.
// Assumes the device only pulls the data wire low through its enable.
`default_nettype none

module dacrs_host (
	// Clock and device drive
	input wire logic clk_in,
	input wire logic dev_oe_in,
	// Bus pins
	output logic scl_out,
	output logic sda_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic low_ff = 1'b0;
	// Pull-up: a released wire reads high
	assign sda_out = ~(low_ff | dev_oe_in);
	initial scl_out = 1'b1;
	task automatic step();
		repeat (5) @(posedge clk_in);
	endtask
	// Data changes only while the clock is low
	task automatic bit_x(input logic b, output logic r);
		low_ff <= ~b;
		step();
		scl_out <= 1'b1;
		step();
		r = sda_out;
		scl_out <= 1'b0;
		step();
	endtask
	// Also serves as repeated start after an ack slot
	task automatic start();
		low_ff <= 1'b0;
		step();
		scl_out <= 1'b1;
		step();
		low_ff <= 1'b1;
		step();
		scl_out <= 1'b0;
		step();
	endtask
	task automatic stop();
		low_ff <= 1'b1;
		step();
		scl_out <= 1'b1;
		step();
		low_ff <= 1'b0;
		step();
	endtask
	// Ninth slot always released: ack from device or host nack
	task automatic xfer_byte(input logic [7:0] d, output logic [7:0] r,
		output logic ack);
		logic n;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r[i]);
		bit_x(1'b1, n);
		ack = ~n;
	endtask
endmodule

`default_nettype wire

// [verif/test_dac_register_set.sv]
// Bench for the converter register set, driven through the host model.
// Assumes the design constants header on the include path.
`include "dacrs_defines.svh"
`default_nettype none

module test_dac_register_set;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic scl, sda, sda_drv, sda_oe, standby, conv_en, a;
	logic [7:0] code, r;
	int miscompares = 0;
	int checks = 0;
	localparam logic [7:0] AW = {`DACRS_SLAVE_ADDR, 1'b0};
	localparam logic [7:0] AR = {`DACRS_SLAVE_ADDR, `DACRS_RW_READ};
	dacrs_top u_dacrs_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
		.sda_oe_out(sda_oe), .dac_code_out(code),
		.standby_out(standby), .conv_en_out(conv_en));
	dacrs_host u_host (.clk_in(clk_in), .dev_oe_in(sda_oe),
		.scl_out(scl), .sda_out(sda));
	initial
	begin
		forever #5 clk_in = ~clk_in;
	end
	task automatic chk(input string n, input logic [7:0] e, g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic send(input logic [7:0] d);
		u_host.xfer_byte(d, r, a);
		chk("ack", 8'h01, {7'h00, a});
	endtask
	task automatic wr(input logic [7:0] c, d);
		u_host.start();
		send(AW);
		send(c);
		send(d);
		u_host.stop();
	endtask
	// Read without command byte; also the tail of a read-byte
	task automatic rx(input logic [7:0] e);
		u_host.start();
		send(AR);
		u_host.xfer_byte(8'hff, r, a);
		chk("read data", e, r);
		u_host.stop();
	endtask
	task automatic rd(input logic [7:0] c, e);
		u_host.start();
		send(AW);
		send(c);
		rx(e);
	endtask
	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		chk("code", 8'h00, code);
		chk("conv_en", 8'h01, {7'h00, conv_en});
		rd(`DACRS_CMD_SETTINGS, `DACRS_SETTINGS_RESET);
		rd(`DACRS_CMD_CODE, `DACRS_CODE_RESET);
		$display("test reset done");
		wr(`DACRS_CMD_CODE, 8'ha5);
		chk("code", 8'ha5, code);
		rd(`DACRS_CMD_CODE, 8'ha5);
		$display("test code done");
		wr(`DACRS_CMD_SETTINGS, 8'hff);
		chk("standby", 8'h01, {7'h00, standby});
		repeat (2) @(posedge clk_in);
		chk("conv_en", 8'h00, {7'h00, conv_en});
		rd(`DACRS_CMD_SETTINGS, 8'h01);
		rx(8'h01);
		rd(`DACRS_CMD_CODE, 8'ha5);
		u_host.start();
		send(AR);
		for (int i = 7; i >= 0; i--)
			u_host.bit_x(1'b1, r[i]);
		u_host.bit_x(1'b0, a);
		chk("burst first", 8'ha5, r);
		u_host.xfer_byte(8'hff, r, a);
		chk("burst second", 8'ha5, r);
		u_host.stop();
		wr(`DACRS_CMD_SETTINGS, 8'h00);
		chk("standby", 8'h00, {7'h00, standby});
		$display("test settings done");
		wr(8'h02, 8'h3d);
		chk("code", 8'ha5, code);
		chk("standby", 8'h00, {7'h00, standby});
		rd(8'h02, 8'h00);
		u_host.start();
		u_host.xfer_byte({7'h49, 1'b0}, r, a);
		chk("foreign ack", 8'h00, {7'h00, a});
		chk("sda drive", 8'h00, {7'h00, sda_drv});
		u_host.stop();
		chk("code", 8'ha5, code);
		$display("test refusals done");
		wr(`DACRS_CMD_SETTINGS, 8'h01);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		chk("code", `DACRS_CODE_RESET, code);
		chk("standby", 8'h00, {7'h00, standby});
		chk("conv_en", 8'h01, {7'h00, conv_en});
		rx(`DACRS_CODE_RESET);
		$display("test second reset done");
		finish_test();
	end
	// Whole run is near 7000 cycles
	initial
	begin
		repeat (60000) @(posedge clk_in);
		miscompares++;
		finish_test();
	end
endmodule

`default_nettype wire
